// file: hdl/lsl_top.sv
// Lockstep layer between a processor core and the shared processor bus.
// Assumes all bus pins and the hard reset are synchronous to i_clk.
`timescale 1ns/10ps
// Notes on behaviour
// - Checker forwards every bus input to core.
// - Compare outputs only while defined valid.
// - Checker keeps all bus drivers disabled.
// - Any difference outside hard reset raises miscompare indication.
// - Miscompare forces checker into checkstop.
// - Checkstop shown on halt state pin.
// - Not strapped: layer inactive, normal processor.
// - Core behaviour identical in both modes.
// - Checker affects system only by signalling.
// - Strap sampled on last hard reset clock.
// - Bus request, transfer start compared every clock.
// - Busy, retry, parity, disable never compared.
// - Nothing masks checkstop except hard or async reset.
module lsl_top #(
    parameter int ADDR_W = lsl_pkg::ADDR_W,
    parameter int ATTR_W = lsl_pkg::ATTR_W,
    parameter int DATA_W = lsl_pkg::DATA_W
) (
    input  wire logic              i_clk,                    // System clock
    input  wire logic              i_rst_n,                  // Async reset
    input  wire logic              i_hard_reset_n,           // Hard reset
    input  wire logic              i_write_without_ownership_strap_n, // Strap
    input  wire logic              i_bus_request_n,          // Bus pin in
    input  wire logic              i_transfer_start_n,       // Bus pin in
    input  wire logic [ADDR_W-1:0] i_addr,                   // Bus pin in
    input  wire logic [ATTR_W-1:0] i_attr,                   // Bus pin in
    input  wire logic [DATA_W-1:0] i_data,                   // Bus pin in
    input  wire logic              i_core_bus_request_n,     // Core output
    input  wire logic              i_core_transfer_start_n,  // Core output
    input  wire logic [ADDR_W-1:0] i_core_addr,              // Core output
    input  wire logic [ATTR_W-1:0] i_core_attr,              // Core output
    input  wire logic [DATA_W-1:0] i_core_data,              // Core output
    input  wire logic              i_core_req_oe,            // Core drives
    input  wire logic              i_core_start_oe,          // Core drives
    input  wire logic              i_core_addr_oe,           // Core drives
    input  wire logic              i_core_data_oe,           // Core drives
    input  wire logic              i_core_halt,              // Core checkstop
    output logic                   o_core_bus_request_n,     // To core
    output logic                   o_core_transfer_start_n,  // To core
    output logic [ADDR_W-1:0]      o_core_addr,              // To core
    output logic [ATTR_W-1:0]      o_core_attr,              // To core
    output logic [DATA_W-1:0]      o_core_data,              // To core
    output logic                   o_core_force_halt,        // Force stop
    output logic                   o_bus_request_n,          // Pin drive
    output logic                   o_bus_request_oe,         // Pin enable
    output logic                   o_transfer_start_n,       // Pin drive
    output logic                   o_transfer_start_oe,      // Pin enable
    output logic [ADDR_W-1:0]      o_addr,                   // Pin drive
    output logic [ATTR_W-1:0]      o_attr,                   // Pin drive
    output logic                   o_addr_oe,                // Pin enable
    output logic [DATA_W-1:0]      o_data,                   // Pin drive
    output logic                   o_data_oe,                // Pin enable
    output logic                   o_halt_state_out_n,       // Checkstop pin
    output logic                   o_miscompare,             // One-cycle
    output logic                   o_checker_mode            // Mode level
);

    initial
    begin
        if (ADDR_W < 1 || ATTR_W < 1 || DATA_W < 1)
        begin
            $error("lsl_top: bus widths must be at least one");
        end
    end

    typedef struct packed {
        lsl_pkg::lsl_mode_t mode;
        logic               chk;
        logic               force_halt;
        logic               miscmp;
        logic               halt_n;
        logic               fwd_req;
        logic               fwd_start;
        logic [ADDR_W-1:0]  fwd_addr;
        logic [ATTR_W-1:0]  fwd_attr;
        logic [DATA_W-1:0]  fwd_data;
        logic               drv_req;
        logic               drv_start;
        logic [ADDR_W-1:0]  drv_addr;
        logic [ATTR_W-1:0]  drv_attr;
        logic [DATA_W-1:0]  drv_data;
        logic               oe_req;
        logic               oe_start;
        logic               oe_addr;
        logic               oe_data;
    } lsl_state_t;

    localparam int NGRP = 5;

    lsl_state_t           st_reg;
    lsl_state_t           st_next;
    logic [NGRP-1:0]      grp_differ;
    logic [NGRP-1:0]      grp_valid;
    logic                 differ;
    logic                 in_check;
    lsl_pkg::lsl_mode_t   mode_next;

    assign in_check = (st_reg.mode == lsl_pkg::LSL_CHECK);

    assign grp_valid[0] = in_check;
    assign grp_valid[1] = in_check;
    assign grp_valid[2] = in_check
                          && (st_reg.fwd_start == lsl_pkg::PIN_ACTIVE);
    assign grp_valid[3] = grp_valid[2];
    assign grp_valid[4] = in_check && i_core_data_oe;

    lsl_cmp #(.W(1)) u_cmp_req (
        .i_core   (i_core_bus_request_n),
        .i_bus    (st_reg.fwd_req),
        .i_valid  (grp_valid[0]),
        .o_differ (grp_differ[0])
    );
    lsl_cmp #(.W(1)) u_cmp_start (
        .i_core   (i_core_transfer_start_n),
        .i_bus    (st_reg.fwd_start),
        .i_valid  (grp_valid[1]),
        .o_differ (grp_differ[1])
    );
    lsl_cmp #(.W(ADDR_W)) u_cmp_addr (
        .i_core   (i_core_addr),
        .i_bus    (st_reg.fwd_addr),
        .i_valid  (grp_valid[2]),
        .o_differ (grp_differ[2])
    );
    lsl_cmp #(.W(ATTR_W)) u_cmp_attr (
        .i_core   (i_core_attr),
        .i_bus    (st_reg.fwd_attr),
        .i_valid  (grp_valid[3]),
        .o_differ (grp_differ[3])
    );
    lsl_cmp #(.W(DATA_W)) u_cmp_data (
        .i_core   (i_core_data),
        .i_bus    (st_reg.fwd_data),
        .i_valid  (grp_valid[4]),
        .o_differ (grp_differ[4])
    );

    assign differ = |grp_differ;

    always_comb
    begin
        mode_next = st_reg.mode;
        if (!i_hard_reset_n)
        begin
            if (i_write_without_ownership_strap_n == lsl_pkg::PIN_ACTIVE)
            begin
                mode_next = lsl_pkg::LSL_CHECK;
            end
            else
            begin
                mode_next = lsl_pkg::LSL_NORMAL;
            end
        end
        else
        begin
            unique case (st_reg.mode)
                lsl_pkg::LSL_NORMAL: mode_next = lsl_pkg::LSL_NORMAL;
                lsl_pkg::LSL_CHECK:
                begin
                    if (differ)
                    begin
                        mode_next = lsl_pkg::LSL_HALTED;
                    end
                end
                lsl_pkg::LSL_HALTED: mode_next = lsl_pkg::LSL_HALTED;
                default: mode_next = lsl_pkg::LSL_HALTED;
            endcase
        end
        st_next = st_reg;
        st_next.mode = mode_next;
        st_next.chk = (mode_next != lsl_pkg::LSL_NORMAL);
        st_next.force_halt = (mode_next == lsl_pkg::LSL_HALTED);
        st_next.miscmp = i_hard_reset_n && differ;
        st_next.halt_n = !(i_core_halt
                           || (mode_next == lsl_pkg::LSL_HALTED));
        st_next.fwd_req = i_bus_request_n;
        st_next.fwd_start = i_transfer_start_n;
        st_next.fwd_addr = i_addr;
        st_next.fwd_attr = i_attr;
        st_next.fwd_data = i_data;
        st_next.drv_req = i_core_bus_request_n;
        st_next.drv_start = i_core_transfer_start_n;
        st_next.drv_addr = i_core_addr;
        st_next.drv_attr = i_core_attr;
        st_next.drv_data = i_core_data;
        st_next.oe_req = i_core_req_oe;
        st_next.oe_start = i_core_start_oe;
        st_next.oe_addr = i_core_addr_oe;
        st_next.oe_data = i_core_data_oe;
        if (mode_next != lsl_pkg::LSL_NORMAL)
        begin
            st_next.oe_req = lsl_pkg::OE_OFF;
            st_next.oe_start = lsl_pkg::OE_OFF;
            st_next.oe_addr = lsl_pkg::OE_OFF;
            st_next.oe_data = lsl_pkg::OE_OFF;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_reg <= '0;
            st_reg.mode <= lsl_pkg::MODE_RESET;
            st_reg.halt_n <= lsl_pkg::PIN_IDLE;
            st_reg.fwd_req <= lsl_pkg::PIN_IDLE;
            st_reg.fwd_start <= lsl_pkg::PIN_IDLE;
            st_reg.drv_req <= lsl_pkg::PIN_IDLE;
            st_reg.drv_start <= lsl_pkg::PIN_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_core_bus_request_n    = st_reg.fwd_req;
    assign o_core_transfer_start_n = st_reg.fwd_start;
    assign o_core_addr             = st_reg.fwd_addr;
    assign o_core_attr             = st_reg.fwd_attr;
    assign o_core_data             = st_reg.fwd_data;
    assign o_core_force_halt       = st_reg.force_halt;
    assign o_bus_request_n         = st_reg.drv_req;
    assign o_bus_request_oe        = st_reg.oe_req;
    assign o_transfer_start_n      = st_reg.drv_start;
    assign o_transfer_start_oe     = st_reg.oe_start;
    assign o_addr                  = st_reg.drv_addr;
    assign o_attr                  = st_reg.drv_attr;
    assign o_addr_oe               = st_reg.oe_addr;
    assign o_data                  = st_reg.drv_data;
    assign o_data_oe               = st_reg.oe_data;
    assign o_halt_state_out_n      = st_reg.halt_n;
    assign o_miscompare            = st_reg.miscmp;
    assign o_checker_mode          = st_reg.chk;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_DRIVERS_OFF: assert property (
        o_checker_mode |-> !(o_bus_request_oe || o_transfer_start_oe
                             || o_addr_oe || o_data_oe))
        else $error("checker drives the bus");
    AST_FORWARD: assert property (
        ##1 (o_core_addr == $past(i_addr)
             && o_core_data == $past(i_data)))
        else $error("bus input not forwarded to core");
    AST_BR_MISCMP: assert property (
        (in_check && i_hard_reset_n
         && i_core_bus_request_n != o_core_bus_request_n)
        |=> o_miscompare ##0 !o_halt_state_out_n)
        else $error("bus request difference not caught");
    AST_MISCMP_HALT: assert property (
        o_miscompare && $past(in_check) |-> o_core_force_halt)
        else $error("miscompare did not force checkstop");
    AST_HALT_HOLD: assert property (
        (o_core_force_halt && i_hard_reset_n) |=> o_core_force_halt
                                                 && !o_halt_state_out_n)
        else $error("checkstop released without hard reset");
    AST_STRAP: assert property (
        $rose(i_hard_reset_n) |-> o_checker_mode
            == !$past(i_write_without_ownership_strap_n))
        else $error("mode not taken from strap");
    AST_NORMAL_QUIET: assert property (
        (!o_checker_mode && i_hard_reset_n) |=> !o_core_force_halt
            && o_bus_request_oe == $past(i_core_req_oe))
        else $error("normal mode altered by lockstep layer");
    AST_DATA_NOMASK: assert property (
        (in_check && i_hard_reset_n && i_core_data_oe
         && i_core_data != o_core_data) |=> o_core_force_halt)
        else $error("data difference did not checkstop");

    COV_ENTER_CHECK: cover property ($rose(o_checker_mode));
    COV_MISCOMPARE:  cover property (in_check ##1 o_miscompare);
    COV_NORMAL_DRV:  cover property (!o_checker_mode && o_data_oe);
    COV_ADDR_CMP:    cover property (grp_valid[2] ##1 in_check);

endmodule

// file: hdl/lsl_pkg.sv
// Shared widths, mode codes and reset values for the lockstep layer.
// Assumes one system clock and a synchronous hard reset input.
package lsl_pkg;

    localparam int ADDR_W = 32;
    localparam int ATTR_W = 12;
    localparam int DATA_W = 64;

    // Idle and asserted pin levels of active-low signals, and the output-enable off level.
    localparam logic PIN_IDLE   = 1'b1;
    localparam logic PIN_ACTIVE = 1'b0;
    localparam logic OE_OFF     = 1'b0;

    typedef enum logic [1:0] {
        LSL_NORMAL = 2'b00,
        LSL_CHECK  = 2'b01,
        LSL_HALTED = 2'b10
    } lsl_mode_t;

    localparam lsl_mode_t MODE_RESET = LSL_NORMAL;

endpackage

// file: hdl/lsl_cmp.sv
// Masked comparator for one group of bussed outputs.
// Assumes both operands are already aligned to the same clock edge.
`timescale 1ns/10ps
module lsl_cmp #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_core,   // Value from the local core
    input  wire logic [W-1:0] i_bus,    // Value seen on the shared bus
    input  wire logic         i_valid,  // Group is defined valid now
    output logic              o_differ  // Valid and not equal
);

    initial
    begin
        if (W < 1)
        begin
            $error("lsl_cmp: width must be at least one");
        end
    end

    assign o_differ = i_valid && (i_core != i_bus);

endmodule

// file: test/lsl_master_model.sv
// Master processor model: drives the shared bus pins from a random word.
// Assumes the bench hands it a fresh random word on every clock.
`timescale 1ns/10ps
module lsl_master_model (
    input  wire logic                     i_clk,   // System clock
    input  wire logic                     i_rst_n, // Async reset
    input  wire logic [31:0]              i_rand,  // Random word
    output logic                          o_req_n,   // Bus request pin
    output logic                          o_start_n, // Transfer start pin
    output logic [lsl_pkg::ADDR_W-1:0]    o_addr,  // Address pins
    output logic [lsl_pkg::ATTR_W-1:0]    o_attr,  // Attribute pins
    output logic [lsl_pkg::DATA_W-1:0]    o_data   // Data pins
);
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_req_n <= 1'b1;
            o_start_n <= 1'b1;
            o_addr <= '0;
            o_attr <= '0;
            o_data <= '0;
        end
        else
        begin
            o_req_n <= #1 i_rand[0];
            o_start_n <= #1 |i_rand[2:1];
            // Address lines are undriven between starts, so they keep moving.
            o_addr <= #1 (|i_rand[2:1]) ? ~o_addr : i_rand;
            o_attr <= #1 (|i_rand[2:1]) ? ~o_attr : i_rand[31:20];
            o_data <= #1 {i_rand, ~i_rand};
        end
    end
endmodule

// file: test/lsl_top_tb.sv
// Bench for the lockstep layer: scenario sequence and a cycle model.
// Assumes the master model drives the pins and the bench plays the core.
`timescale 1ns/10ps
module lsl_top_tb;
    localparam int AW = lsl_pkg::ADDR_W;
    localparam int TW = lsl_pkg::ATTR_W;
    localparam int DW = lsl_pkg::DATA_W;
    logic          i_clk, i_rst_n, i_hard_reset_n, strap_n, halt_in;
    logic          i_bus_request_n, i_transfer_start_n;
    logic          p_req, p_start, q_req, q_start;
    logic [AW-1:0] i_addr, i_core_addr, p_addr, q_addr, o_core_addr, o_addr;
    logic [TW-1:0] i_attr, i_core_attr, p_attr, q_attr, o_core_attr, o_attr;
    logic [DW-1:0] i_data, i_core_data, p_data, q_data, o_core_data, o_data;
    logic          i_core_bus_request_n, i_core_transfer_start_n;
    logic          i_core_req_oe, i_core_start_oe, i_core_addr_oe;
    logic          i_core_data_oe;
    logic          o_core_bus_request_n, o_core_transfer_start_n, o_data_oe;
    logic          o_core_force_halt, o_bus_request_n, o_bus_request_oe;
    logic          o_transfer_start_n, o_transfer_start_oe, o_addr_oe;
    logic          o_halt_state_out_n, o_miscompare, o_checker_mode;
    logic          mode_c, halted;
    logic [31:0]   rnd;
    int            miscompares, checked, cycles, hit;

    lsl_master_model master (.i_clk, .i_rst_n, .i_rand(rnd),
        .o_req_n(i_bus_request_n), .o_start_n(i_transfer_start_n),
        .o_addr(i_addr), .o_attr(i_attr), .o_data(i_data));
    lsl_top dut (.i_clk, .i_rst_n, .i_hard_reset_n,
        .i_write_without_ownership_strap_n(strap_n), .i_core_halt(halt_in),
        .i_bus_request_n, .i_transfer_start_n, .i_addr, .i_attr, .i_data,
        .i_core_bus_request_n, .i_core_transfer_start_n, .i_core_addr,
        .i_core_attr, .i_core_data, .i_core_req_oe, .i_core_start_oe,
        .i_core_addr_oe, .i_core_data_oe, .o_core_bus_request_n,
        .o_core_transfer_start_n, .o_core_addr, .o_core_attr, .o_core_data,
        .o_core_force_halt, .o_bus_request_n, .o_bus_request_oe,
        .o_transfer_start_n, .o_transfer_start_oe, .o_addr, .o_attr,
        .o_addr_oe, .o_data, .o_data_oe, .o_halt_state_out_n,
        .o_miscompare, .o_checker_mode);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_of_test();
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // Each of n clocks: model update, compare, then new core and random drive.
    task automatic step(input int n);
        logic dif;
        repeat (n)
        begin
            @(posedge i_clk);
            {p_req, p_start, p_addr, p_attr, p_data} = {i_bus_request_n,
                i_transfer_start_n, i_addr, i_attr, i_data};
            dif = 1'b0;
            if (!i_hard_reset_n)
            begin
                mode_c = !strap_n;
                halted = 1'b0;
            end
            else if (mode_c && !halted)
            begin
                dif = (i_core_bus_request_n !== q_req)
                    || (i_core_transfer_start_n !== q_start)
                    || (!q_start
                        && {i_core_addr, i_core_attr} !== {q_addr, q_attr})
                    || (i_core_data_oe && i_core_data !== q_data);
                halted = dif;
            end
            #1;
            chk("core_side", {p_req, p_start, p_addr, p_attr},
                {o_core_bus_request_n, o_core_transfer_start_n,
                 o_core_addr, o_core_attr});
            chk("core_data", p_data, o_core_data);
            chk("pin_drive", {i_core_bus_request_n,
                i_core_transfer_start_n, i_core_addr, i_core_attr},
                {o_bus_request_n, o_transfer_start_n, o_addr, o_attr});
            chk("pin_data", i_core_data, o_data);
            chk("pin_oe", {i_core_req_oe, i_core_start_oe,
                i_core_addr_oe, i_core_data_oe} & {4{!mode_c}},
                {o_bus_request_oe, o_transfer_start_oe, o_addr_oe,
                 o_data_oe});
            chk("status", {!(halt_in || halted), dif, mode_c, halted},
                {o_halt_state_out_n, o_miscompare, o_checker_mode,
                 o_core_force_halt});
            {q_req, q_start, q_addr, q_attr, q_data}
                = {p_req, p_start, p_addr, p_attr, p_data};
            rnd = lfsr(rnd);
            {i_core_req_oe, i_core_start_oe, i_core_addr_oe} = rnd[6:4];
            i_core_data_oe = rnd[3] || hit == 4;
            i_core_bus_request_n = p_req ^ (hit == 1);
            i_core_transfer_start_n = p_start ^ (hit == 2);
            // Corrupt groups that are not valid; a real fault only on demand.
            i_core_addr = p_addr ^ AW'(p_start || hit == 3);
            i_core_attr = p_attr ^ TW'(p_start);
            i_core_data = p_data ^ DW'(!i_core_data_oe || hit == 4);
            if (hit != 3 || !p_start)
                hit = 0;
        end
    endtask

    task automatic hard_reset(input logic chk_mode);
        i_hard_reset_n = 1'b0;
        strap_n = 1'b0;
        step(2);
        strap_n = !chk_mode;
        step(1);
        i_hard_reset_n = 1'b1;
        strap_n = 1'b1;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    initial
    begin
        // Async reset starts asserted and is held for ten clocks.
        {i_rst_n, i_hard_reset_n, strap_n, halt_in, mode_c, halted} = 6'h00;
        {q_req, q_start, q_addr, q_attr, q_data} = {2'b11, 108'h0};
        {i_core_bus_request_n, i_core_transfer_start_n} = 2'b11;
        {i_core_addr, i_core_attr, i_core_data} = '0;
        {i_core_req_oe, i_core_start_oe, i_core_addr_oe} = 3'h0;
        i_core_data_oe = 1'b0;
        rnd = 32'hfa1c;
        hit = 0;
        repeat (10) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        hard_reset(1'b0);
        step(20);
        hit = 1;
        step(3);
        halt_in = 1'b1;
        step(2);
        halt_in = 1'b0;
        for (int k = 1; k <= 4; k++)
        begin
            hard_reset(1'b1);
            step(20);
            hit = k;
            step(25);
            hit = 1;
            step(3);
        end
        hard_reset(1'b0);
        step(5);
        end_of_test();
    end
endmodule
